// ===== hw/spu_baud.sv
`timescale 1ns/1ps
// Oversampling tick for one direction: 16 ticks per bit
module spu_baud (
	input wire logic clk_sys,
	input wire logic srst,
	input wire spu_pkg::spu_mode_t mode,
	input wire logic rate_double,
	input wire logic t2_sel,
	input wire logic t1_ovf,
	input wire logic t2_ovf,
	output logic tick16,
	output logic bit_tick
);
	import spu_pkg::*;

	logic half_reg;
	logic [3:0] div_reg;
	logic fixed_rate;
	logic use_t2;
	logic src;
	logic halve;

	// Source choice; fixed mode takes every core clock as its source
	assign fixed_rate = (mode == SPU_MODE_UART9F);
	assign use_t2 = t2_sel && !fixed_rate;
	assign src = fixed_rate ? 1'b1 : (use_t2 ? t2_ovf : t1_ovf);
	// Timer 2 overflows 16 times a bit directly, others are halved unless doubled
	assign halve = !use_t2 && !rate_double;
	assign tick16 = src && (!halve || half_reg);
	assign bit_tick = tick16 && (div_reg == SPU_OVS_LAST);

	// Divide-by-two and bit divider
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			half_reg <= 1'b0;
			div_reg <= 4'h0;
		end else begin
			if (src)
				half_reg <= ~half_reg;
			if (tick16)
				div_reg <= div_reg + 4'h1;
		end
	end

endmodule : spu_baud

// ===== hw/spu_uart.sv
`timescale 1ns/1ps
module spu_uart (
	input wire logic clk_sys,
	input wire logic srst,
	input wire spu_pkg::spu_wb_req_t wb_req,
	output logic [31:0] wb_rdata,
	output logic wb_ack,
	input wire logic rxd_pin_level,
	output spu_pkg::spu_pin_out_t pins
);
	import spu_pkg::*;

	// Address match on the word, low two bits ignored
	function automatic logic spu_hit(input logic [7:0] adr, input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction : spu_hit

	// Software-visible state
	logic mode_sel_b0_reg, mode_sel_b1_reg, multiproc_enable_reg, rx_enable_reg;
	logic tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg;
	logic rx_ninth_bit_next, tx_done_flag_next, rx_done_flag_next;
	logic rate_double_reg, t2_tx_clock_sel_reg, t2_rx_clock_sel_reg;
	logic [7:0] timer1_reload_value_reg, timer2_reload_high_reg, timer2_reload_low_reg;
	logic [7:0] rx_buf_reg, rx_buf_next;
	logic wb_ack_reg;
	logic [31:0] wb_rdata_reg, rd_word;

	// Timers and engines
	logic [3:0] mach_cnt_reg;
	logic [7:0] t1_cnt_reg;
	logic t2_pre_reg;
	logic [15:0] t2_cnt_reg;
	spu_tx_state_t tx_state_reg, tx_state_next;
	logic [10:0] tx_frame_reg, tx_frame_next;
	logic [3:0] tx_left_reg, tx_left_next;
	logic tx_done_set;
	spu_rx_state_t rx_state_reg, rx_state_next;
	logic [3:0] rx_sub_reg, rx_sub_next, rx_cnt_reg, rx_cnt_next;
	logic [7:0] rx_sr_reg, rx_sr_next;
	logic rx_nine_reg, rx_nine_next, rx_prev_reg;
	logic rx_accept, rx_ninth_val;
	logic [3:0] m0_phase_reg, m0_phase_next;
	logic txd_reg, txd_next, rxd_drive_reg, rxd_drive_next, rxd_en_reg, rxd_en_next;

	// Bus decode; one request is taken per ack
	logic req_live, wr_lo, wr_hi;
	logic wr_ctrl, wr_data, wr_pwr, wr_t2ctl, wr_t1rld, wr_t2lo, wr_t2hi;
	logic [7:0] wdat;
	assign req_live = wb_req.cyc && wb_req.stb && !wb_ack_reg;
	assign wr_lo = req_live && wb_req.we && wb_req.sel[0];
	assign wr_hi = req_live && wb_req.we && wb_req.sel[1];
	assign wdat = wb_req.dat[7:0];
	assign wr_ctrl = wr_lo && spu_hit(wb_req.adr, SPU_ADR_CTRL);
	assign wr_data = wr_lo && spu_hit(wb_req.adr, SPU_ADR_DATA);
	assign wr_pwr = wr_lo && spu_hit(wb_req.adr, SPU_ADR_PWR);
	assign wr_t2ctl = wr_lo && spu_hit(wb_req.adr, SPU_ADR_T2CTL);
	assign wr_t1rld = wr_lo && spu_hit(wb_req.adr, SPU_ADR_T1RLD);
	assign wr_t2lo = wr_lo && spu_hit(wb_req.adr, SPU_ADR_T2RLD);
	assign wr_t2hi = wr_hi && spu_hit(wb_req.adr, SPU_ADR_T2RLD);

	// Read selection; unmapped words read as zero
	logic [7:0] ctrl_byte;
	assign ctrl_byte = {mode_sel_b0_reg, mode_sel_b1_reg, multiproc_enable_reg, rx_enable_reg,
		tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
	assign rd_word = spu_hit(wb_req.adr, SPU_ADR_CTRL) ? {24'h000000, ctrl_byte} :
		spu_hit(wb_req.adr, SPU_ADR_DATA) ? {24'h000000, rx_buf_reg} :
		spu_hit(wb_req.adr, SPU_ADR_PWR) ? {24'h000000, rate_double_reg, 7'h00} :
		spu_hit(wb_req.adr, SPU_ADR_T2CTL) ?
			{26'h0, t2_rx_clock_sel_reg, t2_tx_clock_sel_reg, 4'h0} :
		spu_hit(wb_req.adr, SPU_ADR_T1RLD) ? {24'h000000, timer1_reload_value_reg} :
		spu_hit(wb_req.adr, SPU_ADR_T2RLD) ?
			{16'h0000, timer2_reload_high_reg, timer2_reload_low_reg} : 32'h00000000;
	assign wb_rdata = wb_rdata_reg;
	assign wb_ack = wb_ack_reg;

	// Mode decode
	spu_mode_t mode;
	logic nine_bit;
	assign mode = spu_mode_t'({mode_sel_b0_reg, mode_sel_b1_reg});
	assign nine_bit = (mode == SPU_MODE_UART9F) || (mode == SPU_MODE_UART9V);

	// Timer 1: 8-bit autoreload stepping once per 12-clock machine cycle
	logic mach_tick, t1_ovf;
	assign mach_tick = (mach_cnt_reg == SPU_MACH_LAST);
	assign t1_ovf = mach_tick && (t1_cnt_reg == 8'hff);

	// Timer 2 runs only while a direction selects it; stopped, it rests at its reload
	// value, so a new rate takes effect at once instead of after a full 16-bit pass
	logic t2_run, t2_step, t2_ovf;
	assign t2_run = t2_tx_clock_sel_reg || t2_rx_clock_sel_reg;
	assign t2_step = t2_run && t2_pre_reg;
	assign t2_ovf = t2_step && (t2_cnt_reg == 16'hffff);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mach_cnt_reg <= 4'h0;
			t1_cnt_reg <= SPU_BYTE_RST;
			t2_pre_reg <= 1'b0;
			t2_cnt_reg <= SPU_T2RLD_RST;
		end else begin
			mach_cnt_reg <= mach_tick ? 4'h0 : mach_cnt_reg + 4'h1;
			if (mach_tick)
				t1_cnt_reg <= t1_ovf ? timer1_reload_value_reg : t1_cnt_reg + 8'h01;
			t2_pre_reg <= t2_run ? ~t2_pre_reg : 1'b0;
			if (!t2_run)
				t2_cnt_reg <= {timer2_reload_high_reg, timer2_reload_low_reg};
			else if (t2_step)
				t2_cnt_reg <= t2_ovf ? {timer2_reload_high_reg, timer2_reload_low_reg} :
					t2_cnt_reg + 16'h0001;
		end
	end

	// Per-direction rate choice lets each side use a different timer
	logic tx_bit_tick, rx_tick16;
	spu_baud u_tx_baud (
		.clk_sys(clk_sys),
		.srst(srst),
		.mode(mode),
		.rate_double(rate_double_reg),
		.t2_sel(t2_tx_clock_sel_reg),
		.t1_ovf(t1_ovf),
		.t2_ovf(t2_ovf),
		.tick16(),
		.bit_tick(tx_bit_tick)
	);
	spu_baud u_rx_baud (
		.clk_sys(clk_sys),
		.srst(srst),
		.mode(mode),
		.rate_double(rate_double_reg),
		.t2_sel(t2_rx_clock_sel_reg),
		.t1_ovf(t1_ovf),
		.t2_ovf(t2_ovf),
		.tick16(rx_tick16),
		.bit_tick()
	);

	// Shift-mode phase: clock low six cycles, high six
	logic m0_active, m0_end;
	assign m0_active = (tx_state_reg == SPU_TX_SHIFT0) || (rx_state_reg == SPU_RX_SHIFT0);
	assign m0_end = (m0_phase_reg == SPU_M0_LAST);
	assign m0_phase_next = (wr_data || !m0_active || m0_end) ? 4'h0 :
		m0_phase_reg + 4'h1;

	// Transmit engine; a new write always restarts it
	always_comb begin
		tx_state_next = tx_state_reg;
		tx_frame_next = tx_frame_reg;
		tx_left_next = tx_left_reg;
		tx_done_set = 1'b0;
		if (wr_data) begin
			if (mode == SPU_MODE_SHIFT) begin
				tx_state_next = SPU_TX_SHIFT0;
				tx_frame_next = {3'b111, wdat};
				tx_left_next = SPU_DATA_BITS;
			end else begin
				tx_state_next = SPU_TX_WAIT;
				// Ninth slot is the only stop bit in the 8-bit UART
				tx_frame_next = {1'b1, nine_bit ? tx_ninth_bit_reg : 1'b1, wdat, 1'b0};
				tx_left_next = nine_bit ? SPU_FRAME9_BITS : SPU_FRAME8_BITS;
			end
		end else begin
			case (tx_state_reg)
				SPU_TX_WAIT: begin
					if (tx_bit_tick)
						tx_state_next = SPU_TX_SEND;
				end
				SPU_TX_SEND: begin
					if (tx_bit_tick) begin
						if (tx_left_reg == 4'h1) begin
							tx_state_next = SPU_TX_IDLE;
						end else begin
							tx_frame_next = {1'b1, tx_frame_reg[10:1]};
							tx_left_next = tx_left_reg - 4'h1;
							tx_done_set = (tx_left_reg == 4'h2);
						end
					end
				end
				SPU_TX_SHIFT0: begin
					if (m0_end) begin
						tx_frame_next = {1'b1, tx_frame_reg[10:1]};
						tx_left_next = tx_left_reg - 4'h1;
						if (tx_left_reg == 4'h1) begin
							tx_state_next = SPU_TX_IDLE;
							tx_done_set = 1'b1;
						end
					end
				end
				default: tx_state_next = SPU_TX_IDLE;
			endcase
		end
	end

	// Receive engine
	logic [3:0] rx_last;
	assign rx_last = nine_bit ? 4'h9 : 4'h8;
	always_comb begin
		rx_state_next = rx_state_reg;
		rx_sub_next = rx_sub_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_sr_next = rx_sr_reg;
		rx_nine_next = rx_nine_reg;
		rx_accept = 1'b0;
		rx_ninth_val = rx_ninth_bit_reg;
		case (rx_state_reg)
			SPU_RX_IDLE: begin
				if (mode == SPU_MODE_SHIFT) begin
					if (rx_enable_reg && !rx_done_flag_reg && !wr_data &&
						tx_state_reg == SPU_TX_IDLE) begin
						rx_state_next = SPU_RX_SHIFT0;
						rx_cnt_next = SPU_DATA_BITS;
					end
				end else if (rx_tick16 && rx_enable_reg && rx_prev_reg && !rxd_pin_level) begin
					rx_state_next = SPU_RX_START;
					rx_sub_next = 4'h0;
				end
			end
			SPU_RX_START: begin
				if (rx_tick16) begin
					if (rx_sub_reg == SPU_OVS_MID) begin
						// A glitch shorter than half a bit is not a start
						rx_state_next = rxd_pin_level ? SPU_RX_IDLE : SPU_RX_DATA;
						rx_sub_next = 4'h0;
						rx_cnt_next = 4'h0;
					end else begin
						rx_sub_next = rx_sub_reg + 4'h1;
					end
				end
			end
			SPU_RX_DATA: begin
				if (rx_tick16) begin
					if (rx_sub_reg == SPU_OVS_LAST) begin
						rx_sub_next = 4'h0;
						rx_cnt_next = rx_cnt_reg + 4'h1;
						if (rx_cnt_reg < SPU_DATA_BITS)
							rx_sr_next = {rxd_pin_level, rx_sr_reg[7:1]};
						if (rx_cnt_reg == SPU_DATA_BITS)
							rx_nine_next = rxd_pin_level;
						if (rx_cnt_reg == rx_last) begin
							rx_state_next = SPU_RX_IDLE;
							rx_accept = !rx_done_flag_reg && rxd_pin_level;
							rx_ninth_val = nine_bit ? rx_nine_reg : rxd_pin_level;
						end
					end else begin
						rx_sub_next = rx_sub_reg + 4'h1;
					end
				end
			end
			SPU_RX_SHIFT0: begin
				// A buffer write takes the shift pins over for transmit
				if (wr_data) begin
					rx_state_next = SPU_RX_IDLE;
				end else begin
					if (m0_phase_reg == SPU_M0_HALF)
						rx_sr_next = {rxd_pin_level, rx_sr_reg[7:1]};
					if (m0_end) begin
						rx_cnt_next = rx_cnt_reg - 4'h1;
						if (rx_cnt_reg == 4'h1) begin
							rx_state_next = SPU_RX_IDLE;
							rx_accept = !rx_done_flag_reg;
						end
					end
				end
			end
			default: rx_state_next = SPU_RX_IDLE;
		endcase
	end

	// Flags: hardware set wins over a software clear in the same cycle
	assign tx_done_flag_next = tx_done_set ||
		(wr_ctrl ? wdat[SPU_CTL_TX_DONE] : tx_done_flag_reg);
	assign rx_done_flag_next = rx_accept ||
		(wr_ctrl ? wdat[SPU_CTL_RX_DONE] : rx_done_flag_reg);
	assign rx_ninth_bit_next = rx_accept ? rx_ninth_val :
		(wr_ctrl ? wdat[SPU_CTL_RX_NINTH] : rx_ninth_bit_reg);
	assign rx_buf_next = rx_accept ? rx_sr_reg : rx_buf_reg;

	// Pin values from next state so the flag and the line move together
	logic m0_next_active;
	assign m0_next_active = (tx_state_next == SPU_TX_SHIFT0) || (rx_state_next == SPU_RX_SHIFT0);
	assign txd_next = m0_next_active ? (m0_phase_next >= SPU_M0_HALF) :
		(tx_state_next == SPU_TX_SEND) ? tx_frame_next[0] : 1'b1;
	assign rxd_en_next = (tx_state_next == SPU_TX_SHIFT0);
	assign rxd_drive_next = rxd_en_next ? tx_frame_next[0] : 1'b1;
	assign pins.txd_level = txd_reg;
	assign pins.rxd_drive = rxd_drive_reg;
	assign pins.rxd_drive_en = rxd_en_reg;

	// Engine state
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_state_reg <= SPU_TX_IDLE;
			tx_frame_reg <= 11'h7ff;
			tx_left_reg <= 4'h0;
			rx_state_reg <= SPU_RX_IDLE;
			rx_sub_reg <= 4'h0;
			rx_cnt_reg <= 4'h0;
			rx_sr_reg <= SPU_BYTE_RST;
			rx_nine_reg <= 1'b0;
			rx_prev_reg <= 1'b1;
			m0_phase_reg <= 4'h0;
			txd_reg <= 1'b1;
			rxd_drive_reg <= 1'b1;
			rxd_en_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_frame_reg <= tx_frame_next;
			tx_left_reg <= tx_left_next;
			rx_state_reg <= rx_state_next;
			rx_sub_reg <= rx_sub_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_sr_reg <= rx_sr_next;
			rx_nine_reg <= rx_nine_next;
			if (rx_tick16)
				rx_prev_reg <= rxd_pin_level;
			m0_phase_reg <= m0_phase_next;
			txd_reg <= txd_next;
			rxd_drive_reg <= rxd_drive_next;
			rxd_en_reg <= rxd_en_next;
		end
	end

	// Register file and bus answer, ack one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			{mode_sel_b0_reg, mode_sel_b1_reg, multiproc_enable_reg, rx_enable_reg} <= 4'h0;
			tx_ninth_bit_reg <= 1'b0;
			rx_ninth_bit_reg <= 1'b0;
			tx_done_flag_reg <= 1'b0;
			rx_done_flag_reg <= 1'b0;
			rate_double_reg <= 1'b0;
			t2_tx_clock_sel_reg <= 1'b0;
			t2_rx_clock_sel_reg <= 1'b0;
			timer1_reload_value_reg <= SPU_BYTE_RST;
			{timer2_reload_high_reg, timer2_reload_low_reg} <= SPU_T2RLD_RST;
			rx_buf_reg <= SPU_BYTE_RST;
			wb_ack_reg <= 1'b0;
			wb_rdata_reg <= 32'h00000000;
		end else begin
			if (wr_ctrl) begin
				mode_sel_b0_reg <= wdat[SPU_CTL_MODE_B0];
				mode_sel_b1_reg <= wdat[SPU_CTL_MODE_B1];
				multiproc_enable_reg <= wdat[SPU_CTL_MULTIPROC];
				rx_enable_reg <= wdat[SPU_CTL_RX_EN];
				tx_ninth_bit_reg <= wdat[SPU_CTL_TX_NINTH];
			end
			rx_ninth_bit_reg <= rx_ninth_bit_next;
			tx_done_flag_reg <= tx_done_flag_next;
			rx_done_flag_reg <= rx_done_flag_next;
			rx_buf_reg <= rx_buf_next;
			if (wr_pwr)
				rate_double_reg <= wdat[SPU_PWR_RATE_DOUBLE];
			if (wr_t2ctl) begin
				t2_tx_clock_sel_reg <= wdat[SPU_T2_TX_SEL];
				t2_rx_clock_sel_reg <= wdat[SPU_T2_RX_SEL];
			end
			if (wr_t1rld)
				timer1_reload_value_reg <= wdat;
			if (wr_t2lo)
				timer2_reload_low_reg <= wdat;
			if (wr_t2hi)
				timer2_reload_high_reg <= wb_req.dat[15:8];
			wb_ack_reg <= req_live;
			if (req_live && !wb_req.we)
				wb_rdata_reg <= rd_word;
		end
	end

endmodule : spu_uart

// ===== inc/spu_pkg.sv
package spu_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] SPU_ADR_CTRL = 8'h00;
	localparam logic [7:0] SPU_ADR_DATA = 8'h04;
	localparam logic [7:0] SPU_ADR_PWR = 8'h08;
	localparam logic [7:0] SPU_ADR_T2CTL = 8'h0c;
	localparam logic [7:0] SPU_ADR_T1RLD = 8'h10;
	localparam logic [7:0] SPU_ADR_T2RLD = 8'h14;

	// Field positions in serial_control_reg
	localparam int SPU_CTL_MODE_B0 = 7;
	localparam int SPU_CTL_MODE_B1 = 6;
	localparam int SPU_CTL_MULTIPROC = 5;
	localparam int SPU_CTL_RX_EN = 4;
	localparam int SPU_CTL_TX_NINTH = 3;
	localparam int SPU_CTL_RX_NINTH = 2;
	localparam int SPU_CTL_TX_DONE = 1;
	localparam int SPU_CTL_RX_DONE = 0;
	// Field positions in power_control_reg and timer2_control_reg
	localparam int SPU_PWR_RATE_DOUBLE = 7;
	localparam int SPU_T2_RX_SEL = 5;
	localparam int SPU_T2_TX_SEL = 4;

	// Values after reset
	localparam logic [7:0] SPU_BYTE_RST = 8'h00;
	localparam logic [15:0] SPU_T2RLD_RST = 16'h0000;

	// Cycle counts
	localparam logic [3:0] SPU_M0_LAST = 4'hb;
	localparam logic [3:0] SPU_M0_HALF = 4'h6;
	localparam logic [3:0] SPU_MACH_LAST = 4'hb;
	localparam logic [3:0] SPU_OVS_LAST = 4'hf;
	localparam logic [3:0] SPU_OVS_MID = 4'h7;
	localparam logic [3:0] SPU_DATA_BITS = 4'h8;
	localparam logic [3:0] SPU_FRAME8_BITS = 4'ha;
	localparam logic [3:0] SPU_FRAME9_BITS = 4'hb;

	typedef enum logic [1:0] {
		SPU_MODE_SHIFT = 2'b00,
		SPU_MODE_UART8 = 2'b01,
		SPU_MODE_UART9F = 2'b10,
		SPU_MODE_UART9V = 2'b11
	} spu_mode_t;

	typedef enum logic [1:0] {
		SPU_TX_IDLE = 2'b00,
		SPU_TX_WAIT = 2'b01,
		SPU_TX_SEND = 2'b10,
		SPU_TX_SHIFT0 = 2'b11
	} spu_tx_state_t;

	typedef enum logic [1:0] {
		SPU_RX_IDLE = 2'b00,
		SPU_RX_START = 2'b01,
		SPU_RX_DATA = 2'b10,
		SPU_RX_SHIFT0 = 2'b11
	} spu_rx_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} spu_wb_req_t;

	typedef struct packed {
		logic txd_level;
		logic rxd_drive;
		logic rxd_drive_en;
	} spu_pin_out_t;

endpackage : spu_pkg

// ===== sim/spu_uart_bench.sv
`timescale 1ns/1ps
module spu_uart_bench;
	import spu_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	spu_wb_req_t wb_req = '0;
	logic [31:0] wb_rdata;
	logic wb_ack;
	spu_pin_out_t pins;
	logic peer_level;
	logic rxd_pin_level;
	int n_errors = 0;
	int n_compared = 0;
	logic [31:0] rd;
	logic [31:0] rv;
	logic [7:0] d8;
	logic [7:0] adrs[7] = '{SPU_ADR_PWR, SPU_ADR_T2CTL, SPU_ADR_T1RLD, SPU_ADR_T2RLD, 8'h18,
		SPU_ADR_CTRL, SPU_ADR_DATA};
	logic [31:0] masks[5] = '{32'h80, 32'h30, 32'hff, 32'hffff, 32'h0};
	// Shared receive pin: block drives it in shift transmit, peer otherwise
	assign rxd_pin_level = pins.rxd_drive_en ? pins.rxd_drive : peer_level;
	always #12.5 clk_sys = ~clk_sys;
	spu_uart DUT (.clk_sys(clk_sys), .srst(srst), .wb_req(wb_req), .wb_rdata(wb_rdata),
		.wb_ack(wb_ack), .rxd_pin_level(rxd_pin_level), .pins(pins));
	spu_uart_peer peer (.clk_sys(clk_sys), .pins(pins), .rxd_level(peer_level));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// One classic cycle; held until ack is sampled high
	task automatic wb_cycle(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int k;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr_en, adr: a, sel: 4'hf, dat: d};
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (wb_ack === 1'b1) break;
		end
		rd = wb_rdata;
		if (k == 50) begin
			n_errors++;
			tally_and_finish();
		end
		wb_req <= '0;
		@(posedge clk_sys);
	endtask : wb_cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb_cycle(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb_cycle(1'b0, a, 32'h0);
		check(s, rd & m, e);
	endtask : rdchk
	function automatic logic [31:0] ctl(input logic [1:0] m, input logic rx_en, input logic n9);
		ctl = '0;
		ctl[SPU_CTL_MODE_B0] = m[1];
		ctl[SPU_CTL_MODE_B1] = m[0];
		ctl[SPU_CTL_RX_EN] = rx_en;
		ctl[SPU_CTL_TX_NINTH] = n9;
	endfunction : ctl
	// Expected line bits, start first; ten-bit frames end in one stop level
	function automatic logic [10:0] frame(input logic [7:0] d, input logic n9, input int nb);
		frame = {2'b11, d, 1'b0};
		if (nb == 11) frame[9] = n9;
	endfunction : frame
	// Transmit then receive, with overrun, held flags and a bad stop bit
	task automatic uart_round(input logic [1:0] m, input int tper, input int rper, input int nb);
		logic [7:0] d;
		logic n9;
		logic [10:0] f;
		logic [10:0] got;
		logic ok;
		d = 8'($urandom);
		n9 = 1'($urandom);
		f = frame(d, n9, nb);
		wr(SPU_ADR_CTRL, ctl(m, 1'b1, n9));
		fork
			peer.uart_get(tper, nb, got, ok);
			begin
				wr(SPU_ADR_DATA, {24'h0, d});
				rdchk("tx_done early", SPU_ADR_CTRL, 32'h2, 32'h0);
			end
		join
		// Peer returns on a falling edge; bus requests start after a rising one
		@(posedge clk_sys);
		check("tx frame", {ok, got}, {1'b1, f});
		rdchk("tx_done", SPU_ADR_CTRL, 32'h2, 32'h2);
		peer.uart_put(rper, nb, f);
		rdchk("rx flags", SPU_ADR_CTRL, 32'h5, {29'h0, f[9], 2'b01});
		rdchk("rx data", SPU_ADR_DATA, 32'hff, {24'h0, d});
		peer.uart_put(rper, nb, frame(~d, n9, nb));
		rdchk("overrun", SPU_ADR_DATA, 32'hff, {24'h0, d});
		rdchk("flags held", SPU_ADR_CTRL, 32'h3, 32'h3);
		wr(SPU_ADR_CTRL, ctl(m, 1'b1, n9));
		peer.uart_put(rper, nb, f & ~(11'h1 << (nb - 1)));
		rdchk("bad stop", SPU_ADR_CTRL, 32'h1, 32'h0);
	endtask : uart_round
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(81500));
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		foreach (adrs[i]) rdchk("reset", adrs[i], 32'hffffffff, 32'h0);
		for (int i = 0; i < 5; i++) begin
			rv = $urandom;
			wr(adrs[i], rv);
			rdchk("readback", adrs[i], 32'hffffffff, rv & masks[i]);
		end
		// Stop timer 2 so it rests at the new reload value before it runs again
		wr(SPU_ADR_T2CTL, 32'h0);
		wr(SPU_ADR_T2RLD, 32'hfffe);
		wr(SPU_ADR_T2CTL, 32'h1 << SPU_T2_TX_SEL);
		wr(SPU_ADR_T1RLD, 32'hff);
		// Shift mode transmit, then receive
		d8 = 8'($urandom);
		wr(SPU_ADR_CTRL, ctl(SPU_MODE_SHIFT, 1'b0, 1'b0));
		fork
			peer.shift_get(rv[7:0]);
			wr(SPU_ADR_DATA, {24'h0, d8});
		join
		// Done flag follows the last rising shift clock by about half a bit
		repeat (12) @(posedge clk_sys);
		check("shift tx", rv[7:0], d8);
		rdchk("shift tx_done", SPU_ADR_CTRL, 32'h2, 32'h2);
		d8 = 8'($urandom);
		fork
			peer.shift_put(d8);
			wr(SPU_ADR_CTRL, ctl(SPU_MODE_SHIFT, 1'b1, 1'b0));
		join
		// Peer is done at the last sample; the flag sets at the end of that bit
		repeat (12) @(posedge clk_sys);
		rdchk("shift rx_done", SPU_ADR_CTRL, 32'h1, 32'h1);
		rdchk("shift rx", SPU_ADR_DATA, 32'hff, {24'h0, d8});
		wr(SPU_ADR_CTRL, ctl(SPU_MODE_SHIFT, 1'b0, 1'b0));
		for (int d = 0; d < 2; d++) begin
			wr(SPU_ADR_PWR, d << SPU_PWR_RATE_DOUBLE);
			uart_round(SPU_MODE_UART9F, 32 >> d, 32 >> d, 11);
		end
		// Timer 2 sends while timer 1 receives, then swapped
		uart_round(SPU_MODE_UART9V, 32 * 2, (12 * 32) >> 1, 11);
		wr(SPU_ADR_T2CTL, 32'h1 << SPU_T2_RX_SEL);
		uart_round(SPU_MODE_UART8, (12 * 32) >> 1, 32 * 2, 10);
		tally_and_finish();
	end
endmodule : spu_uart_bench

// ===== sim/spu_uart_peer.sv
`timescale 1ns/1ps
module spu_uart_peer (
	input wire logic clk_sys,
	input wire spu_pkg::spu_pin_out_t pins,
	output logic rxd_level
);
	import spu_pkg::*;
	// Idle line is high, as the pin pull-up leaves it
	initial rxd_level = 1'b1;
	// Take one frame, sampled mid-bit on the falling edge, start bit first
	task automatic uart_get(input int per, input int nb, output logic [10:0] bits, output logic ok);
		int n;
		ok = 1'b0;
		bits = 11'h7ff;
		for (n = 0; n < 300000 && pins.txd_level; n++) @(negedge clk_sys);
		if (pins.txd_level) return;
		for (n = 0; n < nb; n++) begin
			repeat (n == 0 ? per / 2 : per) @(negedge clk_sys);
			bits[n] = pins.txd_level;
		end
		ok = 1'b1;
	endtask : uart_get
	// Send one frame, start bit first; line back to idle after stop
	task automatic uart_put(input int per, input int nb, input logic [10:0] bits);
		int n;
		for (n = 0; n < nb; n++) begin
			rxd_level <= bits[n];
			repeat (per) @(posedge clk_sys);
		end
		rxd_level <= 1'b1;
	endtask : uart_put
	// Shift register: take data at each rising shift clock
	task automatic shift_get(output logic [7:0] data);
		int n;
		int k;
		data = 8'h00;
		for (n = 0; n < 8; n++) begin
			for (k = 0; k < 400 && pins.txd_level; k++) @(negedge clk_sys);
			for (k = 0; k < 400 && !pins.txd_level; k++) @(negedge clk_sys);
			data[n] = pins.rxd_drive & pins.rxd_drive_en;
		end
	endtask : shift_get
	// Shift register: new bit only after the rising clock that took the last
	task automatic shift_put(input logic [7:0] data);
		int n;
		int k;
		for (n = 0; n < 8; n++) begin
			@(posedge clk_sys);
			rxd_level <= data[n];
			for (k = 0; k < 400 && pins.txd_level; k++) @(negedge clk_sys);
			for (k = 0; k < 400 && !pins.txd_level; k++) @(negedge clk_sys);
		end
		@(posedge clk_sys);
		rxd_level <= 1'b1;
	endtask : shift_put
endmodule : spu_uart_peer

// ===== sim/spu_uart_sva.sv
`timescale 1ns/1ps
module spu_uart_sva (
	input wire logic clk_sys,
	input wire logic srst,
	input wire spu_pkg::spu_wb_req_t wb_req,
	input wire logic [31:0] wb_rdata,
	input wire logic wb_ack,
	input wire logic rxd_pin_level,
	input wire spu_pkg::spu_pin_out_t pins
);
	import spu_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic [1:0] mode_reg;
	logic dbl_reg;
	logic [9:0] low_len_reg;
	logic take_wr;
	logic unmapped;
	// Write taken on this edge, low byte enabled
	assign take_wr = wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack && wb_req.sel[0];
	assign unmapped = wb_req.adr[7:2] > SPU_ADR_T2RLD[7:2];
	// Shadow of mode and rate bits, so frame timing can be judged
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_reg <= 2'h0;
			dbl_reg <= 1'b0;
		end else if (take_wr && wb_req.adr[7:2] == SPU_ADR_CTRL[7:2]) begin
			mode_reg <= {wb_req.dat[SPU_CTL_MODE_B0], wb_req.dat[SPU_CTL_MODE_B1]};
		end else if (take_wr && wb_req.adr[7:2] == SPU_ADR_PWR[7:2]) begin
			dbl_reg <= wb_req.dat[SPU_PWR_RATE_DOUBLE];
		end
	end
	// Low run length on the transmit line; idle is high so in the UART modes every low run is in a frame
	always_ff @(posedge clk_sys) begin
		if (srst || pins.txd_level) begin
			low_len_reg <= 10'h000;
		end else begin
			low_len_reg <= low_len_reg + 10'h001;
		end
	end
	a_ack_single: assert property (wb_ack |=> !wb_ack)
		else $error("ack held longer than one cycle");
	a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
		else $error("request not answered in one cycle");
	a_ack_cause: assert property (wb_ack |-> $past(wb_req.cyc && wb_req.stb))
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_ack && !wb_req.we && unmapped |-> wb_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (wb_ack && !wb_req.we |-> wb_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_shift_clk_half: assert property ($fell(pins.txd_level) && mode_reg == SPU_MODE_SHIFT
		|-> (!pins.txd_level)[*6] ##1 pins.txd_level)
		else $error("shift clock low phase not six cycles");
	a_fixed_bit_len: assert property ($rose(pins.txd_level) && mode_reg == SPU_MODE_UART9F
		|-> low_len_reg != 10'h000 && low_len_reg % (dbl_reg ? 10'h010 : 10'h020) == 10'h000)
		else $error("fixed rate bit length wrong");
	a_drive_shift_only: assert property (pins.rxd_drive_en |-> mode_reg == SPU_MODE_SHIFT)
		else $error("receive pin driven outside shift mode");
	a_data_clk_low: assert property (pins.rxd_drive_en && $past(pins.rxd_drive_en)
		&& $changed(pins.rxd_drive) |-> !pins.txd_level)
		else $error("shift data changed while clock high");
	// Main scenarios reached
	c_tx_launch: cover property (take_wr && wb_req.adr == SPU_ADR_DATA);
	c_shift_clock: cover property ($fell(pins.txd_level) && mode_reg == SPU_MODE_SHIFT);
	c_fixed_frame: cover property ($rose(pins.txd_level) && mode_reg == SPU_MODE_UART9F);
endmodule : spu_uart_sva

bind spu_uart spu_uart_sva u_sva (.clk_sys(clk_sys), .srst(srst), .wb_req(wb_req),
	.wb_rdata(wb_rdata), .wb_ack(wb_ack), .rxd_pin_level(rxd_pin_level), .pins(pins));
